// File: include/sirq_pkg.sv
// Constants and types for the serial interrupt peripheral
// Contract
// - Shared wire driven tri-state by every agent
// - All wire timing counted in link clocks
// - Cycle: start, data frames, one stop
// - Quiet start: peripheral pulls low one clock
// - Continuous: only host starts, four to eight; code takes any low run of four or more
// - Reset enters continuous mode, await host
// - Count frames from start pulse rising edge
// - Frame is sample, recovery, turn-around
// - Sample: pull low only if request active
// - Recovery drive high, turn-around release
// - Frames one to three at 2,5,8
// - Frames 4-32 every three clocks, rest unassigned
// - Two-clock stop selects quiet next cycle
// - Three-clock stop selects continuous next cycle
package sirq_pkg;

   localparam int SLOT_COUNT = 32;
   localparam int SYNC_STAGES = 2;

   localparam logic [3:0] START_MIN_LOW  = 4'h4;
   localparam logic [3:0] STOP_QUIET_LOW = 4'h2;
   localparam logic [3:0] STOP_CONT_LOW  = 4'h3;
   localparam logic [3:0] LOW_RUN_MAX    = 4'hF;

   localparam logic [1:0] PH_SAMPLE   = 2'h0;
   localparam logic [1:0] PH_RECOVERY = 2'h1;
   localparam logic [1:0] PH_TURN     = 2'h2;

   localparam logic [5:0] FRAME_FIRST = 6'h01;
   localparam logic [5:0] FRAME_MAX   = 6'h3F;

   localparam logic RESET_QUIET = 1'b0;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_START  = 3'b010,
      ST_FRAMES = 3'b100
   } state_t;

endpackage

// File: include/sirq_link_if.sv
// Sampled link clock edge and wire level passed to the frame logic
`timescale 1ns/1ns
interface sirq_link_if;
   logic pclk_rise;
   logic wire_lvl;
   modport src (output pclk_rise, output wire_lvl);
   modport dst (input pclk_rise, input wire_lvl);
endinterface

// File: logic/link_sampler.sv
// Two-stage synchronisers for link clock and wire, link clock edge finder
`timescale 1ns/1ns
module link_sampler (
   input  wire logic  core_clk_i,
   input  wire logic  srst_i,
   input  wire logic  pci_clk_i,
   input  wire logic  wire_i,
   sirq_link_if.src   lk
);
   import sirq_pkg::*;

   typedef struct packed {
      logic [1:0] clk_meta;
      logic [1:0] clk_sync;
      logic       clk_prev;
      logic       wire_meta;
      logic       wire_sync;
   } smp_t;

   smp_t r;
   smp_t next_r;

   always_comb begin
      next_r           = r;
      next_r.clk_meta  = {1'b0, pci_clk_i};
      next_r.clk_sync  = {1'b0, r.clk_meta[0]};
      next_r.clk_prev  = r.clk_sync[0];
      next_r.wire_meta = wire_i;
      next_r.wire_sync = r.wire_meta;
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         r <= '{clk_meta: 2'h0, clk_sync: 2'h0, clk_prev: 1'b0,
                wire_meta: 1'b1, wire_sync: 1'b1};
      end else begin
         r <= next_r;
      end
   end

   // Link clock rise seen on the synchronised copy only
   assign lk.pclk_rise = r.clk_sync[0] & ~r.clk_prev;
   assign lk.wire_lvl  = r.wire_sync;
endmodule

// File: logic/serial_irq_peripheral.sv
// Peripheral end of the shared serial interrupt wire
`timescale 1ns/1ns
module serial_irq_peripheral #(
   parameter int SLOTS = sirq_pkg::SLOT_COUNT
) (
   input  wire logic             core_clk_i,
   input  wire logic             srst_i,
   input  wire logic             pci_clk_i,
   input  wire logic             shared_interrupt_wire_i,
   input  wire logic [SLOTS-1:0] irq_i,
   input  wire logic [SLOTS-1:0] slot_en_i,
   output logic                  shared_interrupt_wire_o,
   output logic                  shared_interrupt_wire_oe_o,
   output logic                  quiet_mode_o,
   output logic                  cycle_active_o
);
   import sirq_pkg::*;

   generate
      if (SLOTS < 1 || SLOTS > SLOT_COUNT) begin : g_bad
         $error("SLOTS must lie between 1 and 32");
      end
      // Start and stop are told apart by low run length alone
      if (START_MIN_LOW <= STOP_CONT_LOW) begin : g_bad_start
         $error("Start low run must exceed the stop low run");
      end
      if (STOP_QUIET_LOW >= STOP_CONT_LOW) begin : g_bad_stop
         $error("Quiet stop must be shorter than continuous stop");
      end
      // Frame counter must pass the last owned frame
      if (int'(FRAME_MAX) <= SLOTS) begin : g_bad_frame
         $error("Frame counter too narrow for SLOTS");
      end
   endgenerate

   typedef struct packed {
      state_t           state;
      logic             quiet;
      logic [3:0]       low_run;
      logic [1:0]       phase;
      logic [5:0]       frame;
      logic [SLOTS-1:0] sent;
      logic             drv;
      logic             oe;
   } regs_t;

   regs_t r;
   regs_t next_r;

   sirq_link_if lk ();

   link_sampler u_sampler (
      .core_clk_i (core_clk_i),
      .srst_i     (srst_i),
      .pci_clk_i  (pci_clk_i),
      .wire_i     (shared_interrupt_wire_i),
      .lk         (lk)
   );

   logic pending;

   // Requests differing from what was last reported in own frames
   assign pending = |((irq_i ^ r.sent) & slot_en_i);

   always_comb begin
      logic       lvl;
      logic       own;
      logic [5:0] idx;
      lvl    = lk.wire_lvl;
      own    = 1'b0;
      idx    = 6'h00;
      next_r = r;
      if (lk.pclk_rise) begin
         // Length of the current low run on the wire
         if (lvl) begin
            next_r.low_run = 4'h0;
         end else if (r.low_run != LOW_RUN_MAX) begin
            next_r.low_run = 4'(r.low_run + 4'h1);
         end
         // Released unless a phase below claims the wire
         next_r.oe  = 1'b0;
         next_r.drv = 1'b1;
         unique case (r.state)
            ST_IDLE: begin
               if (lvl && r.low_run >= START_MIN_LOW) begin
                  // Start pulse just ended: reference edge
                  next_r.state = ST_FRAMES;
                  next_r.phase = PH_RECOVERY;
                  next_r.frame = 6'h00;
               end else if (r.quiet && lvl && r.low_run == 4'h0
                            && pending) begin
                  next_r.state = ST_START;
                  next_r.oe    = 1'b1;
                  next_r.drv   = 1'b0;
               end
            end
            ST_START: begin
               // One clock low, then host holds the pulse
               next_r.state = ST_IDLE;
            end
            ST_FRAMES: begin
               if (lvl && r.low_run >= STOP_CONT_LOW) begin
                  next_r.state = ST_IDLE;
                  next_r.quiet = 1'b0;
               end else if (lvl && r.low_run == STOP_QUIET_LOW) begin
                  next_r.state = ST_IDLE;
                  next_r.quiet = 1'b1;
               end else begin
                  if (r.phase == PH_TURN) begin
                     next_r.phase = PH_SAMPLE;
                     if (r.frame != FRAME_MAX) begin
                        next_r.frame = 6'(r.frame + 6'h01);
                     end
                  end else begin
                     next_r.phase = 2'(r.phase + 2'h1);
                  end
                  // Frame n samples 3n-1 clocks past the start edge
                  idx = 6'(next_r.frame - FRAME_FIRST);
                  own = next_r.frame >= FRAME_FIRST
                        && next_r.frame <= 6'(SLOTS)
                        && slot_en_i[idx[4:0]];
                  if (own && next_r.phase == PH_SAMPLE) begin
                     next_r.oe  = irq_i[idx[4:0]];
                     next_r.drv = 1'b0;
                     next_r.sent[idx[4:0]] = irq_i[idx[4:0]];
                  end else if (own && next_r.phase == PH_RECOVERY) begin
                     next_r.oe  = 1'b1;
                     next_r.drv = 1'b1;
                  end
               end
            end
            default: begin
               next_r.state = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         r.state   <= ST_IDLE;
         r.quiet   <= RESET_QUIET;
         r.low_run <= 4'h0;
         r.phase   <= PH_SAMPLE;
         r.frame   <= 6'h00;
         r.sent    <= '0;
         r.drv     <= 1'b1;
         r.oe      <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   // Only low or the recovery high is ever driven
   assign shared_interrupt_wire_o    = r.drv;
   assign shared_interrupt_wire_oe_o = r.oe;
   assign quiet_mode_o               = r.quiet;
   assign cycle_active_o             = r.state == ST_FRAMES;
endmodule

// File: test/sirq_monitor.sv
// Port checker for the serial interrupt peripheral
`timescale 1ns/1ns
module sirq_monitor #(parameter int SLOTS = 32) (
   input wire logic             core_clk_i,
   input wire logic             srst_i,
   input wire logic [SLOTS-1:0] irq_i,
   input wire logic [SLOTS-1:0] slot_en_i,
   input wire logic             shared_interrupt_wire_o,
   input wire logic             shared_interrupt_wire_oe_o,
   input wire logic             quiet_mode_o,
   input wire logic             cycle_active_o
);
   wire oe = shared_interrupt_wire_oe_o;
   wire lo = oe & ~shared_interrupt_wire_o;
   wire hi = oe & shared_interrupt_wire_o;
   wire act = cycle_active_o;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   sequence s_samp;
      lo && act ##1 !lo;
   endsequence
   AST_RST: assert property (disable iff (1'b0)
      srst_i |=> !oe && !quiet_mode_o) else $error("reset");
   AST_STAND: assert property ($rose(oe) |=> oe [*6])
      else $error("short drive");
   AST_ONE: assert property ($rose(lo) |-> ##[1:10] !lo)
      else $error("long low");
   AST_RECOV: assert property (s_samp |-> hi) else $error("recovery");
   AST_TURN: assert property ($fell(hi) |-> !oe [*6])
      else $error("turn-around");
   AST_CONT: assert property (!quiet_mode_o && !act |-> !lo)
      else $error("continuous start");
   AST_REQ: assert property (lo && act |-> |(irq_i & slot_en_i))
      else $error("sample low");
   AST_MODE: assert property ($changed(quiet_mode_o) |-> ##[0:1] !act)
      else $error("mode change");
endmodule
bind serial_irq_peripheral sirq_monitor #(.SLOTS(SLOTS)) mon (
   .core_clk_i                 (core_clk_i),
   .srst_i                     (srst_i),
   .irq_i                      (irq_i),
   .slot_en_i                  (slot_en_i),
   .shared_interrupt_wire_o    (shared_interrupt_wire_o),
   .shared_interrupt_wire_oe_o (shared_interrupt_wire_oe_o),
   .quiet_mode_o               (quiet_mode_o),
   .cycle_active_o             (cycle_active_o)
);

// File: test/sirq_host.sv
// Host controller model on the shared wire, link clock source
`timescale 1ns/1ns
module sirq_host (
   input  wire logic dev_lo_i,
   output logic      pci_clk_o,
   output wire logic wire_o
);
   logic drv = 1'b0;
   logic val = 1'b1;
   initial begin
      pci_clk_o = 1'b0;
      forever #80 pci_clk_o = ~pci_clk_o;
   end
   assign wire_o = (drv ? val : 1'b1) & ~dev_lo_i;
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge pci_clk_o);
         drv <= 1'b1;
         val <= 1'b0;
      end
      @(posedge pci_clk_o);
      val <= 1'b1;
      @(posedge pci_clk_o);
      drv <= 1'b0;
   endtask
endmodule

// File: test/serial_irq_peripheral_tb.sv
// Bench for the serial interrupt peripheral
`timescale 1ns/1ns
module serial_irq_peripheral_tb;
   logic        core_clk_i = 1'b0;
   logic        srst_i = 1'b1;
   logic [31:0] irq = 32'h0;
   logic [31:0] en = 32'h1;
   logic        wo, woe, quiet, act, pclk, wl;
   int          miscompares = 0;
   int          n_compared = 0;
   int          cyc = 0;
   initial forever #10 core_clk_i = ~core_clk_i;
   serial_irq_peripheral dut (.core_clk_i(core_clk_i), .srst_i(srst_i),
      .pci_clk_i(pclk), .shared_interrupt_wire_i(wl), .irq_i(irq),
      .slot_en_i(en), .shared_interrupt_wire_o(wo),
      .shared_interrupt_wire_oe_o(woe), .quiet_mode_o(quiet),
      .cycle_active_o(act));
   sirq_host host (.dev_lo_i(woe & ~wo), .pci_clk_o(pclk), .wire_o(wl));
   task automatic chk(input logic ok, input string m);
      n_compared++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("mismatch at %0t: %s", $time, m);
      end
   endtask
   task automatic summarize;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic frames(input int s, input logic req, input int stop);
      repeat (2 + 3 * s) @(posedge pclk);
      chk(woe === req && (!req || wo === 1'b0), "sample");
      @(posedge pclk);
      chk(act === 1'b1 && woe === 1'b1 && wo === 1'b1, "recovery");
      @(posedge pclk);
      chk(woe === 1'b0, "turn-around");
      repeat (94 - 3 * s) @(posedge pclk);
      host.pulse(stop);
      chk(quiet === (stop == 2) && act === 1'b0, "stop");
   endtask
   task automatic cont_cycle;
      irq <= 32'h1;
      repeat (16) @(posedge pclk);
      chk(woe === 1'b0 && quiet === 1'b0 && act === 1'b0, "reset mode");
      host.pulse(6);
      frames(0, 1'b1, 2);
   endtask
   task automatic quiet_cycle;
      repeat (16) @(posedge pclk);
      chk(woe === 1'b0, "idle start");
      @(posedge core_clk_i);
      irq <= 32'h0;
      for (int i = 0; i < 400 && !(woe === 1'b1 && wo === 1'b0); i++)
         @(posedge core_clk_i);
      chk(woe === 1'b1 && wo === 1'b0 && quiet === 1'b1, "quiet");
      host.pulse(4);
      frames(0, 1'b0, 3);
   endtask
   task automatic cont_hold;
      @(posedge core_clk_i);
      irq <= 32'h1;
      repeat (16) @(posedge pclk);
      chk(woe === 1'b0 && quiet === 1'b0, "cont start");
   endtask
   task automatic slot_cycle;
      @(posedge core_clk_i);
      en  <= 32'h00010001;
      irq <= 32'h00010000;
      host.pulse(5);
      frames(16, 1'b1, 3);
   endtask
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         miscompares++;
         summarize;
      end
   end
   initial begin
      repeat (3) @(posedge core_clk_i);
      srst_i <= 1'b0;
      cont_cycle;
      quiet_cycle;
      cont_hold;
      slot_cycle;
      summarize;
   end
endmodule
